// >>> servo_parameter_store.sv
// Parameter store of a servo driver: four parameter groups behind a
// classic Wishbone slave, power-up activation, write protection, checks.
// Assumes one clock, rst_i as power-on reset and power_up_i as a later
// power-up event that keeps the stored values.
// Notes on behaviour
// R01: Power-cycle parameters change only at next power-up
// R02: Codes 0000h/000Bh/000Ch open one, three, four groups
// R03: 100Bh/100Ch read-limited, only write-protect itself writable; code limits reads only under 100Bh, 100Ch reads all four groups
// R04: Factory write-protect 000Ch, itself power-cycle effective
// R05: Gear counts accepted only within 1 to 16384
// R06: Gear ratio, motor-station, count product checked
// R07: Unusable regenerative option raises parameter error
// R08: Four prefixed groups, permissions applied per group
// R09: Operator leaves reserved parameters at defaults
// R10: Absolute detection only on enabling code, power-cycle
// R11: Settle window drives complete and in-position outputs
// R12: Writes to protected groups are ignored
// R13: Power-cycle values validated when applied at power-up
`timescale 1ns/100ps
`default_nettype none

module servo_parameter_store #(
  parameter int unsigned  GROUP_DEPTH       = 32,
  parameter logic [15:0]  REGEN_VALID_MASK  = 16'h0001
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [11:0]                           wb_adr_i,
  input  wire logic [3:0]                            wb_sel_i,
  input  wire logic [31:0]                           wb_dat_i,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  input  wire logic                                  power_up_i,
  input  wire logic signed [31:0]                    position_error_i,
  input  wire logic                                  motion_done_i,
  output logic                                       irq_o,
  output logic                                       parameter_error_alarm_o,
  output logic                                       absolute_detect_o,
  output logic                                       movement_complete_output_o,
  output logic                                       in_position_output_o,
  output servo_parameter_store_pkg::active_cfg_type  active_cfg_o
);

  localparam int unsigned MEM_DEPTH = 4 * GROUP_DEPTH;

  servo_parameter_store_pkg::wb_req_type req;
  logic [15:0]                           param_mem [0:MEM_DEPTH-1];
  servo_parameter_store_pkg::active_cfg_type active_r;
  logic [2:0]                            status_r;
  logic [2:0]                            mask_r;
  logic [15:0]                           station_r;
  logic                                  boot_apply_r;
  logic                                  gear_error_r;
  logic                                  regen_error_r;
  logic                                  param_error_r;
  logic                                  ack_r;
  logic [31:0]                           dat_r;

  logic                                  apply;
  logic [1:0]                            grp;
  logic [6:0]                            idx;
  logic                                  in_params;
  logic                                  in_range;
  logic [31:0]                           mem_addr;
  logic                                  read_ok;
  logic                                  write_ok;
  logic                                  value_ok;
  logic                                  commit;
  logic                                  param_write;
  logic                                  factory_init;
  logic [15:0]                           wr_value;
  logic [15:0]                           cur_value;
  logic [15:0]                           stored_settle;
  logic [31:0]                           machine_gear_teeth;
  logic [31:0]                           motor_gear_teeth;
  logic [31:0]                           station_count;
  logic                                  gear_bad;
  logic                                  regen_bad;
  logic [2:0]                            events;
  logic [31:0]                           error_size;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // Factory value of each stored parameter
  function automatic logic [15:0] default_value(input logic [1:0] g, input logic [6:0] i);
    logic [15:0] v;
    v = 16'h0000;
    if (g == servo_parameter_store_pkg::GROUP_BASIC) begin
      case (i)
        servo_parameter_store_pkg::GEAR_MACHINE_IDX:    v = servo_parameter_store_pkg::GEAR_COUNT_RST;
        servo_parameter_store_pkg::GEAR_MOTOR_IDX:      v = servo_parameter_store_pkg::GEAR_COUNT_RST;
        servo_parameter_store_pkg::TUNING_MODE_IDX:     v = servo_parameter_store_pkg::TUNING_MODE_RST;
        servo_parameter_store_pkg::TUNING_RESPONSE_IDX: v = servo_parameter_store_pkg::TUNING_RESPONSE_RST;
        servo_parameter_store_pkg::SETTLE_WINDOW_IDX:   v = servo_parameter_store_pkg::SETTLE_WINDOW_RST;
        servo_parameter_store_pkg::FWD_TORQUE_IDX:      v = servo_parameter_store_pkg::TORQUE_CAP_RST;
        servo_parameter_store_pkg::REV_TORQUE_IDX:      v = servo_parameter_store_pkg::TORQUE_CAP_RST;
        servo_parameter_store_pkg::MAKER_SETTING_IDX:   v = servo_parameter_store_pkg::MAKER_SETTING_RST; // R09
        servo_parameter_store_pkg::ENCODER_PULSE_IDX:   v = servo_parameter_store_pkg::ENCODER_PULSE_RST;
        servo_parameter_store_pkg::WRITE_PROTECT_IDX:   v = servo_parameter_store_pkg::WRITE_PROTECT_RST; // R04
        default:                                        v = 16'h0000;
      endcase
    end
    return v;
  endfunction : default_value

  function automatic logic [31:0] basic_addr(input logic [6:0] i);
    return {25'h000_0000, i};
  endfunction : basic_addr

  // Address decode
  assign grp       = req.adr[10:9];
  assign idx       = req.adr[8:2];
  assign in_params = ~req.adr[11];
  assign in_range  = in_params && (32'(idx) < GROUP_DEPTH);
  assign mem_addr  = 32'(grp) * GROUP_DEPTH + 32'(idx);
  assign commit    = req.cyc && req.stb && req.we && ack_r;

  // Group permissions from the active write-protect value only
  always_comb begin
    read_ok  = 1'b0;
    write_ok = 1'b0;
    case (active_r.write_protect)
      servo_parameter_store_pkg::WP_THREE_RW: begin
        read_ok  = (grp != servo_parameter_store_pkg::GROUP_IO); // R02 R08
        write_ok = read_ok;
      end
      servo_parameter_store_pkg::WP_ALL_RW: begin
        read_ok  = 1'b1; // R02
        write_ok = 1'b1;
      end
      servo_parameter_store_pkg::WP_BASIC_RD_LOCKED: begin
        read_ok  = (grp == servo_parameter_store_pkg::GROUP_BASIC); // R03
        write_ok = read_ok && (idx == servo_parameter_store_pkg::WRITE_PROTECT_IDX);
      end
      servo_parameter_store_pkg::WP_ALL_RD_LOCKED: begin
        read_ok  = 1'b1; // R03
        write_ok = (grp == servo_parameter_store_pkg::GROUP_BASIC) &&
                   (idx == servo_parameter_store_pkg::WRITE_PROTECT_IDX);
      end
      default: begin
        // Unlisted codes fall back to the most restrictive open setting
        read_ok  = (grp == servo_parameter_store_pkg::GROUP_BASIC); // R02
        write_ok = read_ok;
      end
    endcase
  end

  // Byte-lane merge and range checks on the value being written
  always_comb begin
    cur_value = in_range ? param_mem[mem_addr] : 16'h0000;
    wr_value  = cur_value;
    if (req.sel[0]) begin
      wr_value[7:0] = req.dat[7:0];
    end
    if (req.sel[1]) begin
      wr_value[15:8] = req.dat[15:8];
    end
    value_ok = 1'b1;
    if (grp == servo_parameter_store_pkg::GROUP_BASIC) begin
      case (idx)
        servo_parameter_store_pkg::GEAR_MACHINE_IDX,
        servo_parameter_store_pkg::GEAR_MOTOR_IDX: begin
          value_ok = (32'(wr_value) >= servo_parameter_store_pkg::GEAR_COUNT_MIN) &&
                     (32'(wr_value) <= servo_parameter_store_pkg::GEAR_COUNT_MAX); // R05
        end
        servo_parameter_store_pkg::SETTLE_WINDOW_IDX: begin
          value_ok = (wr_value <= servo_parameter_store_pkg::SETTLE_WINDOW_MAX); // R11
        end
        default: value_ok = 1'b1;
      endcase
    end
  end

  // Writes land on the ack edge only, once per request
  assign param_write  = commit && in_range && write_ok && value_ok; // R12
  assign factory_init = commit && (req.adr == servo_parameter_store_pkg::CONTROL_ADR) &&
                        req.sel[0] && req.dat[servo_parameter_store_pkg::CTRL_FACTORY];

  // Power-up happens once after reset release and on every power_up_i pulse
  assign apply = boot_apply_r || power_up_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_apply_r <= 1'b1;
    end else begin
      boot_apply_r <= 1'b0;
    end
  end

  // Stored parameter values; a write here never touches the active copy
  always_ff @(posedge clk_i) begin
    if (rst_i || factory_init) begin
      for (int unsigned k = 0; k < MEM_DEPTH; k++) begin
        param_mem[k] <= default_value(2'(k / GROUP_DEPTH), 7'(k % GROUP_DEPTH)); // R04 R09
      end
    end else if (param_write) begin
      param_mem[mem_addr] <= wr_value; // R08
    end
  end

  // Station count is a block register, outside write protection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      station_r <= servo_parameter_store_pkg::STATION_COUNT_RST;
    end else if (commit && (req.adr == servo_parameter_store_pkg::STATION_ADR)) begin
      if (req.sel[0]) begin
        station_r[7:0] <= req.dat[7:0];
      end
      if (req.sel[1]) begin
        station_r[15:8] <= req.dat[15:8];
      end
    end
  end

  // Checks on the stored values about to become active
  assign machine_gear_teeth = 32'(param_mem[basic_addr(servo_parameter_store_pkg::GEAR_MACHINE_IDX)]);
  assign motor_gear_teeth   = 32'(param_mem[basic_addr(servo_parameter_store_pkg::GEAR_MOTOR_IDX)]);
  assign station_count      = 32'(station_r);

  always_comb begin
    gear_bad = (machine_gear_teeth < servo_parameter_store_pkg::GEAR_COUNT_MIN) ||
               (machine_gear_teeth > servo_parameter_store_pkg::GEAR_COUNT_MAX) ||
               (motor_gear_teeth < servo_parameter_store_pkg::GEAR_COUNT_MIN) ||
               (motor_gear_teeth > servo_parameter_store_pkg::GEAR_COUNT_MAX); // R05
    // Ratio bounds cross-multiplied to avoid a divider
    // 16-bit operands keep every product inside 32 bits
    if (machine_gear_teeth * servo_parameter_store_pkg::GEAR_RATIO_MAX < motor_gear_teeth) begin
      gear_bad = 1'b1; // R06
    end
    if (machine_gear_teeth > motor_gear_teeth * servo_parameter_store_pkg::GEAR_RATIO_MAX) begin
      gear_bad = 1'b1; // R06
    end
    if (motor_gear_teeth * station_count > servo_parameter_store_pkg::MOTOR_STATION_MAX) begin
      gear_bad = 1'b1; // R06
    end
    if (machine_gear_teeth * motor_gear_teeth > servo_parameter_store_pkg::GEAR_PRODUCT_MAX) begin
      gear_bad = 1'b1; // R06
    end
  end

  always_comb begin
    regen_bad = 1'b1;
    if (param_mem[basic_addr(servo_parameter_store_pkg::REGEN_OPTION_IDX)][15:4] == 12'h000) begin
      regen_bad = ~REGEN_VALID_MASK[param_mem[basic_addr(servo_parameter_store_pkg::REGEN_OPTION_IDX)][3:0]]; // R07
    end
  end

  // Active copies of power-cycle parameters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r.control_mode       <= 16'h0000;
      active_r.regen_option       <= 16'h0000;
      active_r.absolute_position  <= 16'h0000;
      active_r.gear_machine       <= servo_parameter_store_pkg::GEAR_COUNT_RST;
      active_r.gear_motor         <= servo_parameter_store_pkg::GEAR_COUNT_RST;
      active_r.rotation_direction <= 16'h0000;
      active_r.encoder_pulses     <= servo_parameter_store_pkg::ENCODER_PULSE_RST;
      active_r.write_protect      <= servo_parameter_store_pkg::WRITE_PROTECT_RST; // R04
    end else if (apply) begin
      active_r.control_mode       <= param_mem[basic_addr(servo_parameter_store_pkg::CONTROL_MODE_IDX)]; // R01
      active_r.regen_option       <= param_mem[basic_addr(servo_parameter_store_pkg::REGEN_OPTION_IDX)];
      active_r.absolute_position  <= param_mem[basic_addr(servo_parameter_store_pkg::ABSOLUTE_POSITION_IDX)]; // R10
      active_r.gear_machine       <= param_mem[basic_addr(servo_parameter_store_pkg::GEAR_MACHINE_IDX)];
      active_r.gear_motor         <= param_mem[basic_addr(servo_parameter_store_pkg::GEAR_MOTOR_IDX)];
      active_r.rotation_direction <= param_mem[basic_addr(servo_parameter_store_pkg::ROTATION_DIR_IDX)];
      active_r.encoder_pulses     <= param_mem[basic_addr(servo_parameter_store_pkg::ENCODER_PULSE_IDX)];
      active_r.write_protect      <= param_mem[basic_addr(servo_parameter_store_pkg::WRITE_PROTECT_IDX)]; // R04
    end
  end

  // Error flags follow the values just made active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gear_error_r  <= 1'b0;
      regen_error_r <= 1'b0;
      param_error_r <= 1'b0;
    end else if (apply) begin
      gear_error_r  <= gear_bad; // R13
      regen_error_r <= regen_bad;
      param_error_r <= gear_bad || regen_bad; // R06 R07 R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      absolute_detect_o <= 1'b0;
    end else if (apply) begin
      absolute_detect_o <= (param_mem[basic_addr(servo_parameter_store_pkg::ABSOLUTE_POSITION_IDX)][3:0] ==
                            servo_parameter_store_pkg::ABSOLUTE_ENABLE_CODE); // R10
    end
  end

  // Settle window is live, not power-cycle
  assign stored_settle = param_mem[basic_addr(servo_parameter_store_pkg::SETTLE_WINDOW_IDX)];
  assign error_size    = position_error_i[31] ? 32'(-position_error_i) : 32'(position_error_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_position_output_o       <= 1'b0;
      movement_complete_output_o <= 1'b0;
    end else begin
      in_position_output_o       <= (error_size <= 32'(stored_settle)); // R11
      movement_complete_output_o <= motion_done_i && (error_size <= 32'(stored_settle)); // R11
    end
  end

  // Events; a new event beats a clear in the same cycle
  assign events[servo_parameter_store_pkg::EV_PARAM_ERROR] = apply && (gear_bad || regen_bad);
  assign events[servo_parameter_store_pkg::EV_WRITE_DENY]  = commit && in_range && !(write_ok && value_ok);
  assign events[servo_parameter_store_pkg::EV_APPLIED]     = apply;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 3'h0;
    end else if (commit && (req.adr == servo_parameter_store_pkg::STATUS_ADR) && req.sel[0]) begin
      status_r <= (status_r & ~req.dat[2:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 3'h0;
    end else if (commit && (req.adr == servo_parameter_store_pkg::MASK_ADR) && req.sel[0]) begin
      mask_r <= req.dat[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_r & mask_r);
    end
  end

  // Wishbone: ack one cycle after the request, held for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req.cyc && req.stb && !ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (req.cyc && req.stb && !ack_r) begin
      dat_r <= 32'h0000_0000;
      if (in_range && read_ok) begin
        dat_r <= {16'h0000, cur_value}; // R03
      end else begin
        case (req.adr)
          servo_parameter_store_pkg::STATUS_ADR:  dat_r <= {29'h0000_0000, status_r};
          servo_parameter_store_pkg::MASK_ADR:    dat_r <= {29'h0000_0000, mask_r};
          servo_parameter_store_pkg::STATION_ADR: dat_r <= {16'h0000, station_r};
          servo_parameter_store_pkg::STATE_ADR:   dat_r <= {active_r.write_protect, 12'h000, regen_error_r,
                                                            gear_error_r, absolute_detect_o, param_error_r};
          default:                                dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o                = ack_r;
  assign wb_dat_o                = dat_r;
  assign parameter_error_alarm_o = param_error_r;
  assign active_cfg_o            = active_r;

endmodule : servo_parameter_store

`default_nettype wire

// >>> servo_parameter_store_pkg.sv
// Constants, register map and carrier types of the servo parameter store.
// Assumes a 32-bit classic Wishbone bus with a 12-bit byte address.
package servo_parameter_store_pkg;

  localparam int unsigned ADR_W          = 12;
  localparam int unsigned DAT_W          = 32;
  localparam int unsigned PARAM_W        = 16;
  localparam int unsigned INDEX_W        = 7;

  // Parameter space: adr[10:9] group, adr[8:2] parameter number
  localparam logic [1:0] GROUP_BASIC     = 2'h0;
  localparam logic [1:0] GROUP_GAIN      = 2'h1;
  localparam logic [1:0] GROUP_EXTENSION = 2'h2;
  localparam logic [1:0] GROUP_IO        = 2'h3;

  // Block registers, adr[11] set
  localparam logic [11:0] STATUS_ADR     = 12'h800;
  localparam logic [11:0] MASK_ADR       = 12'h804;
  localparam logic [11:0] CONTROL_ADR    = 12'h808;
  localparam logic [11:0] STATION_ADR    = 12'h80C;
  localparam logic [11:0] STATE_ADR      = 12'h810;

  // Status, mask and control bit positions
  localparam int unsigned EV_PARAM_ERROR = 0;
  localparam int unsigned EV_WRITE_DENY  = 1;
  localparam int unsigned EV_APPLIED     = 2;
  localparam int unsigned EV_BITS        = 3;
  localparam int unsigned CTRL_FACTORY   = 0;

  // Basic group parameter numbers
  localparam logic [6:0] CONTROL_MODE_IDX    = 7'h01;
  localparam logic [6:0] REGEN_OPTION_IDX    = 7'h02;
  localparam logic [6:0] ABSOLUTE_POSITION_IDX = 7'h03;
  localparam logic [6:0] GEAR_MACHINE_IDX    = 7'h06;
  localparam logic [6:0] GEAR_MOTOR_IDX      = 7'h07;
  localparam logic [6:0] TUNING_MODE_IDX     = 7'h08;
  localparam logic [6:0] TUNING_RESPONSE_IDX = 7'h09;
  localparam logic [6:0] SETTLE_WINDOW_IDX   = 7'h0A;
  localparam logic [6:0] FWD_TORQUE_IDX      = 7'h0B;
  localparam logic [6:0] REV_TORQUE_IDX      = 7'h0C;
  localparam logic [6:0] MAKER_SETTING_IDX   = 7'h0D;
  localparam logic [6:0] ROTATION_DIR_IDX    = 7'h0E;
  localparam logic [6:0] ENCODER_PULSE_IDX   = 7'h0F;
  localparam logic [6:0] WRITE_PROTECT_IDX   = 7'h13;

  // Reset values
  localparam logic [15:0] TUNING_MODE_RST     = 16'h0001;
  localparam logic [15:0] TUNING_RESPONSE_RST = 16'h000C;
  localparam logic [15:0] SETTLE_WINDOW_RST   = 16'h0064;
  localparam logic [15:0] TORQUE_CAP_RST      = 16'h03E8;
  localparam logic [15:0] MAKER_SETTING_RST   = 16'h0002;
  localparam logic [15:0] ENCODER_PULSE_RST   = 16'h0FA0;
  localparam logic [15:0] GEAR_COUNT_RST      = 16'h0001;
  localparam logic [15:0] STATION_COUNT_RST   = 16'h0001;
  localparam logic [15:0] WRITE_PROTECT_RST   = 16'h000C;

  // Write-protect codes
  localparam logic [15:0] WP_BASIC_RW        = 16'h0000;
  localparam logic [15:0] WP_THREE_RW        = 16'h000B;
  localparam logic [15:0] WP_ALL_RW          = 16'h000C;
  localparam logic [15:0] WP_BASIC_RD_LOCKED = 16'h100B;
  localparam logic [15:0] WP_ALL_RD_LOCKED   = 16'h100C;

  // Limits and the absolute-position enabling code
  localparam logic [31:0] GEAR_COUNT_MIN     = 32'h0000_0001;
  localparam logic [31:0] GEAR_COUNT_MAX     = 32'h0000_4000;
  localparam logic [31:0] GEAR_RATIO_MAX     = 32'h0000_270F;
  localparam logic [31:0] MOTOR_STATION_MAX  = 32'h0000_7FFF;
  localparam logic [31:0] GEAR_PRODUCT_MAX   = 32'h0001_86A0;
  localparam logic [15:0] SETTLE_WINDOW_MAX  = 16'h2710;
  localparam logic [3:0]  ABSOLUTE_ENABLE_CODE = 4'h1;

  // Values that take effect only at power-up
  typedef struct packed {
    logic [15:0] control_mode;
    logic [15:0] regen_option;
    logic [15:0] absolute_position;
    logic [15:0] gear_machine;
    logic [15:0] gear_motor;
    logic [15:0] rotation_direction;
    logic [15:0] encoder_pulses;
    logic [15:0] write_protect;
  } active_cfg_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

endpackage : servo_parameter_store_pkg

// >>> servo_parameter_store_chk.sv
// Port checker for the servo parameter store.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module servo_parameter_store_chk (
  input wire logic                                     clk_i,
  input wire logic                                     rst_i,
  input wire logic                                     wb_cyc_i,
  input wire logic                                     wb_stb_i,
  input wire logic [31:0]                              wb_dat_o,
  input wire logic                                     wb_ack_o,
  input wire logic                                     power_up_i,
  input wire logic                                     motion_done_i,
  input wire logic                                     parameter_error_alarm_o,
  input wire logic                                     absolute_detect_o,
  input wire logic                                     movement_complete_output_o,
  input wire logic                                     in_position_output_o,
  input wire servo_parameter_store_pkg::active_cfg_type active_cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_quiet; !power_up_i; endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_data_holds: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
  a_cfg_holds: assert property (s_quiet |=> $stable(active_cfg_o)) else $error("cfg moved");
  a_flags_hold: assert property (s_quiet |=> $stable(parameter_error_alarm_o)
    && $stable(absolute_detect_o)) else $error("flags moved");
  a_detect_tracks: assert property (power_up_i |=> absolute_detect_o
    == (active_cfg_o.absolute_position[3:0] == 4'h1)) else $error("detect flag wrong");
  a_done_needed: assert property (movement_complete_output_o |-> $past(motion_done_i))
    else $error("complete without done");
  a_complete_pos: assert property (movement_complete_output_o |-> in_position_output_o)
    else $error("complete outside window");
endmodule : servo_parameter_store_chk
bind servo_parameter_store servo_parameter_store_chk servo_parameter_store_chk_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .power_up_i, .motion_done_i, .parameter_error_alarm_o,
  .absolute_detect_o, .movement_complete_output_o, .in_position_output_o, .active_cfg_o);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the servo parameter store.
// Assumes the design and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pu = 1'b0, done = 1'b0;
  logic irq, alarm, absd, cmpl, inpos, ack;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, rdat;
  logic signed [31:0] pe = 32'sh0;
  servo_parameter_store_pkg::active_cfg_type cfg;
  int failures = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  servo_parameter_store servo_parameter_store_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .power_up_i(pu), .position_error_i(pe), .motion_done_i(done), .irq_o(irq),
    .parameter_error_alarm_o(alarm), .absolute_detect_o(absd), .movement_complete_output_o(cmpl),
    .in_position_output_o(inpos), .active_cfg_o(cfg));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Called just after a rising edge; holds the request until ack is seen
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk($sformatf("adr %h", a), e, q);
  endtask : rd
  task automatic pup();
    pu <= 1'b1;
    @(posedge clk_i);
    pu <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pup
  task automatic t_reset();
    rd(12'h018, 32'h1);
    rd(12'h04C, 32'h000C);
    rd(12'h028, 32'h0064);
    rd(12'h02C, 32'h03E8);
    rd(12'h900, 32'h0);
    rd(12'h034, 32'h0002);
    chk("active protect", 32'h000C, 32'(cfg.write_protect));
    chk("detect flag", 32'h0, 32'(absd));
    $display("reset test done");
  endtask : t_reset
  task automatic t_gear();
    wr(12'h800, 32'h7);
    wr(12'h018, 32'h0);
    rd(12'h018, 32'h1);
    rd(12'h800, 32'h2);
    wr(12'h018, 32'h4000);
    wr(12'h01C, 32'h4000);
    rd(12'h018, 32'h4000);
    chk("active gear", 32'h1, 32'(cfg.gear_machine));
    pup();
    chk("alarm", 32'h1, 32'(alarm));
    chk("irq masked", 32'h0, 32'(irq));
    chk("active gear", 32'h4000, 32'(cfg.gear_machine));
    wr(12'h804, 32'h1);
    @(posedge clk_i);
    chk("irq", 32'h1, 32'(irq));
    wr(12'h018, 32'h1);
    wr(12'h80C, 32'h4);
    wr(12'h01C, 32'h2000);
    pup();
    chk("alarm", 32'h1, 32'(alarm));
    rd(12'h810, 32'h000C_0005);
    wr(12'h01C, 32'h1);
    pup();
    chk("alarm", 32'h0, 32'(alarm));
    wr(12'h800, 32'h7);
    @(posedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("gear test done");
  endtask : t_gear
  task automatic t_regen();
    wr(12'h008, 32'h5);
    wr(12'h00C, 32'h1);
    pup();
    chk("alarm", 32'h1, 32'(alarm));
    chk("detect flag", 32'h1, 32'(absd));
    wr(12'h008, 32'h0);
    wr(12'h00C, 32'h2);
    pup();
    chk("alarm", 32'h0, 32'(alarm));
    chk("detect flag", 32'h0, 32'(absd));
    $display("regen test done");
  endtask : t_regen
  task automatic t_prot();
    logic [15:0] code [5] = '{16'h000C, 16'h000B, 16'h0000, 16'h100C, 16'h100B};
    logic [31:0] eg [5] = '{1, 2, 0, 2, 0};
    logic [31:0] ei [5] = '{1, 0, 0, 1, 0};
    for (int i = 0; i < 5; i++) begin
      wr(12'h04C, 32'(code[i]));
      pup();
      wr(12'h204, i + 1);
      wr(12'h604, i + 1);
      wr(12'h018, i + 1);
      rd(12'h204, eg[i]);
      rd(12'h604, ei[i]);
      rd(12'h018, i < 3 ? i + 1 : 3);
    end
    wr(12'h04C, 32'h000C);
    pup();
    chk("active protect", 32'h000C, 32'(cfg.write_protect));
    wr(12'h808, 32'h1);
    rd(12'h018, 32'h1);
    $display("protect test done");
  endtask : t_prot
  task automatic t_pos();
    pe <= 32'sd100;
    done <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("complete", 32'h1, 32'(cmpl));
    pe <= -32'sd101;
    repeat (2) @(posedge clk_i);
    chk("in position", 32'h0, 32'(inpos));
    wr(12'h028, 32'h2711);
    rd(12'h028, 32'h0064);
    wr(12'h028, 32'h2710);
    pe <= -32'sd10000;
    done <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("in position", 32'h1, 32'(inpos));
    chk("complete", 32'h0, 32'(cmpl));
    $display("position test done");
  endtask : t_pos
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_gear();
    t_regen();
    t_prot();
    t_pos();
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
